/* bench/sdram_command_interface_tb.sv */
// Self-checking bench for the SDRAM command interface
`timescale 1ns/10ps
module sdram_command_interface_tb;
    import sdrci_pkg::*;
    logic        clk;
    logic        nrst;
    logic        cke;
    logic        cs_n;
    logic [2:0]  cmd;
    logic [1:0]  bank;
    logic [11:0] addr;
    logic        upper_byte_mask;
    logic        lower_byte_mask;
    logic [15:0] wdq;
    logic [15:0] rdq;
    logic [1:0]  oe;
    logic [3:0]  bank_open;
    logic        busy;
    sdrci_pwr_t  pwr;
    int          n_fail = 0;
    int          compares = 0;
    initial clk = 1'b0;
    always #5 clk = ~clk;
    sdrci_core #(.P_STORE_ROW_BITS(2)) DUT (
        .i_clk_sys(clk), .i_nrst(nrst), .i_cke(cke), .i_cs_n(cs_n),
        .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
        .i_bank_select_bit0(bank[0]), .i_bank_select_bit1(bank[1]), .i_addr(addr),
        .i_upper_byte_mask(upper_byte_mask), .i_lower_byte_mask(lower_byte_mask),
        .i_dq(wdq), .o_dq(rdq), .o_dq_oe(oe), .o_bank_open(bank_open),
        .o_burst_busy(busy), .o_power_state(pwr)
    );
    sdrci_ctl_model u_ctl (
        .i_clk_sys(clk), .o_cke(cke), .o_cs_n(cs_n), .o_cmd(cmd), .o_bank(bank),
        .o_addr(addr), .o_upper_byte_mask(upper_byte_mask),
        .o_lower_byte_mask(lower_byte_mask), .o_dq(wdq)
    );
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Contents of bank 1 row 1 after both writes; column 3 kept its old upper byte
    function automatic logic [15:0] mem(input logic [8:0] c);
        return (c == 9'h003) ? 16'h1043 : 16'h2040 + 16'(c);
    endfunction
    // Checks words k0.. of a BL8 burst, one per clock
    task automatic burst(input logic [8:0] s, input logic il, input int k0, input int n);
        logic [8:0] c;
        for (int k = k0; k < k0 + n; k++) begin
            c = il ? s ^ 9'(k) : {s[8:3], s[2:0] + 3'(k)};
            chk("read word", mem(c), rdq);
            chk("read oe", 16'h0003, 16'(oe));
            u_ctl.tick();
        end
    endtask
    task automatic t_reset();
        chk("idle oe", 16'h0000, 16'(oe));
        chk("banks", 16'h0000, 16'(bank_open));
        chk("power", 16'(PWR_ACTIVE), 16'(pwr));
    endtask
    task automatic t_banks();
        u_ctl.activate(2'h0, 12'h000);
        u_ctl.activate(2'h2, 12'h000);
        chk("banks", 16'h0005, 16'(bank_open));
        u_ctl.precharge(2'h2, 1'b0);
        chk("banks", 16'h0001, 16'(bank_open));
        u_ctl.precharge(2'h3, 1'b1);
        chk("banks", 16'h0000, 16'(bank_open));
    endtask
    task automatic t_write();
        u_ctl.activate(2'h1, 12'h001);
        u_ctl.wr(2'h1, 9'h000, 8, 16'h1000, -1);
        chk("write oe", 16'h0000, 16'(oe));
        u_ctl.wr(2'h1, 9'h000, 9, 16'h2040, 3);
    endtask
    // CL2 read, suspended one clock, then a lower mask in mid-burst
    task automatic t_read_cl2();
        u_ctl.issue(CMD_READ, 2'h1, 12'h006);
        u_ctl.nop(1);
        chk("busy", 16'h0001, 16'(busy));
        burst(9'h006, 1'b0, 0, 3);
        u_ctl.o_cke = 1'b0;
        u_ctl.tick();
        chk("frozen word", mem(9'h001), rdq);
        chk("power", 16'(PWR_SUSPEND), 16'(pwr));
        u_ctl.o_cke = 1'b1;
        u_ctl.tick();
        u_ctl.o_lower_byte_mask = 1'b1;
        burst(9'h006, 1'b0, 4, 1);
        u_ctl.o_lower_byte_mask = 1'b0;
        burst(9'h006, 1'b0, 5, 1);
        chk("masked oe", 16'h0002, 16'(oe));
        u_ctl.tick();
        burst(9'h006, 1'b0, 7, 1);
        chk("end oe", 16'h0000, 16'(oe));
        chk("busy", 16'h0000, 16'(busy));
    endtask
    // CL3 interleaved read, a deselected read, then an interrupting read
    task automatic t_read_il();
        u_ctl.precharge(2'h1, 1'b1);
        u_ctl.mode_set(BL_CODE_8, 1'b1, CL_THREE);
        u_ctl.activate(2'h1, 12'h001);
        u_ctl.issue(CMD_READ, 2'h1, 12'h205);
        u_ctl.o_cs_n = 1'b1;
        u_ctl.issue(CMD_READ, 2'h1, 12'h000);
        u_ctl.o_cs_n = 1'b0;
        u_ctl.issue(CMD_READ, 2'h1, 12'h002);
        u_ctl.o_cmd = 3'h7;
        burst(9'h005, 1'b1, 0, 2);
        burst(9'h002, 1'b1, 0, 8);
        chk("end oe", 16'h0000, 16'(oe));
    endtask
    task automatic t_power();
        u_ctl.o_cke = 1'b0;
        u_ctl.tick();
        chk("power", 16'(PWR_DOWN), 16'(pwr));
        u_ctl.o_cke = 1'b1;
        u_ctl.tick();
        chk("power", 16'(PWR_ACTIVE), 16'(pwr));
        // Self refresh is entered only on the edge where clock enable falls
        u_ctl.o_cke = 1'b0;
        u_ctl.o_cmd = CMD_REFRESH;
        u_ctl.tick();
        chk("power", 16'(PWR_SELF), 16'(pwr));
        u_ctl.o_cke = 1'b1;
        u_ctl.nop(2);
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset();
        u_ctl.init();
        t_banks();
        t_write();
        t_read_cl2();
        t_read_il();
        t_power();
        tally_and_finish();
    end
    // Init pause alone is 20000 clocks; the rest needs about a hundred
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
endmodule // sdram_command_interface_tb

/* bench/sdrci_ctl_model.sv */
// Behavioural memory controller that drives the device's command pins
`timescale 1ns/10ps
module sdrci_ctl_model
    import sdrci_pkg::*;
#(
    parameter int P_INIT_CYC = 20000,
    parameter int P_T_MRD    = 2,
    parameter int P_T_RCD    = 3,
    parameter int P_T_RP     = 3
) (
    input  wire logic              i_clk_sys,
    output logic                   o_cke,
    output logic                   o_cs_n,
    output logic      [2:0]        o_cmd,
    output logic      [BANK_W-1:0] o_bank,
    output logic      [ROW_W-1:0]  o_addr,
    output logic                   o_upper_byte_mask,
    output logic                   o_lower_byte_mask,
    output logic      [DQ_W-1:0]   o_dq
);
    initial begin
        o_cke             = 1'b1;
        o_cs_n            = 1'b0;
        o_cmd             = 3'h7;
        o_bank            = 2'h0;
        o_addr            = 12'h000;
        o_upper_byte_mask = 1'b1;
        o_lower_byte_mask = 1'b1;
        o_dq              = 16'h0000;
    end
    task automatic tick();
        @(posedge i_clk_sys);
        #1;
    endtask
    // Outside writes the data lines toggle, so stale data never looks valid
    task automatic nop(input int n);
        repeat (n) begin
            o_cmd = 3'h7;
            o_dq  = ~o_dq;
            tick();
        end
    endtask
    // The command stands until a later call replaces it, so calls may run back to back
    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
        o_cmd  = c;
        o_bank = b;
        o_addr = a;
        tick();
    endtask
    task automatic mode_set(input logic [2:0] bl, input logic il, input logic [2:0] cl);
        issue(CMD_MODE_SET, 2'h0, {5'h00, cl, il, bl});
        nop(P_T_MRD);
    endtask
    task automatic activate(input logic [1:0] b, input logic [11:0] row);
        issue(CMD_ACTIVATE, b, row);
        nop(P_T_RCD);
    endtask
    // Waiting tRP after every close also keeps reopens of one bank tRC apart
    task automatic precharge(input logic [1:0] b, input logic all);
        issue(CMD_PRECHARGE, b, {1'b0, all, 10'h000});
        nop(P_T_RP);
    endtask
    task automatic init();
        nop(P_INIT_CYC);
        o_upper_byte_mask = 1'b0;
        o_lower_byte_mask = 1'b0;
        precharge(2'h0, 1'b1);
        repeat (8) issue(CMD_REFRESH, 2'h0, 12'h000);
        mode_set(BL_CODE_8, 1'b0, 3'h2);
    endtask
    // Word mw carries the upper byte masked; n above the burst sends extra words
    task automatic wr(input logic [1:0] b, input logic [8:0] c, input int n,
                      input logic [15:0] base, input int mw);
        o_bank = b;
        o_addr = {3'h0, c};
        for (int k = 0; k < n; k++) begin
            o_cmd             = (k == 0) ? CMD_WRITE : 3'h7;
            o_dq              = base + 16'(k);
            o_upper_byte_mask = (k == mw);
            tick();
        end
    endtask
endmodule // sdrci_ctl_model

/* hdl/sdrci_burst_gen.sv */
// Column walker for sequential and interleaved bursts
`timescale 1ns/10ps
module sdrci_burst_gen
    import sdrci_pkg::*;
(
    sdrci_burst_if.gen bif
);
    logic [COL_W-1:0] wrap_mask;
    logic [COL_W-1:0] walk;

    always_comb begin
        wrap_mask = sdrci_bl_mask(bif.bl_code);
        // Interleave is meaningless for full page, so it falls back to counting
        if (bif.interleave && (bif.bl_code != BL_CODE_FULL)) begin
            walk = bif.start_col ^ bif.step;
        end else begin
            walk = bif.start_col + bif.step;
        end
        // No carry leaves the wrapping bits
        bif.col = (bif.start_col & ~wrap_mask) | (walk & wrap_mask);
    end

endmodule // sdrci_burst_gen

/* hdl/sdrci_burst_if.sv */
// Burst column request and answer between the core and its address walker
`timescale 1ns/10ps
interface sdrci_burst_if;
    import sdrci_pkg::*;
    logic [COL_W-1:0]   start_col;
    logic [COL_W-1:0]   step;
    logic [MR_BL_W-1:0] bl_code;
    logic               interleave;
    logic [COL_W-1:0]   col;

    modport gen  (input start_col, step, bl_code, interleave, output col);
    modport user (output start_col, step, bl_code, interleave, input col);
endinterface

/* hdl/sdrci_core.sv */
// Command decoder, bank state, mode register and burst data path of the SDRAM
`timescale 1ns/10ps
//
// Contract
// - Address pins give 12-bit row at activate, low 9-bit column at access.
// - Precharge with the all-bank bit high closes all banks, else the selected one.
// - Bank select bits pick the bank to open or access.
// - Chip select high ignores new commands; running bursts continue.
// - Command decoded from RAS#, CAS#, WE# at rising edge with chip select low.
// - Read mask high makes that output byte high-impedance two clocks later.
// - Write mask high blocks that byte in the same cycle.
// - Clock enable low freezes internal clocking: power-down, suspend or self refresh.
// - Upper mask covers data bits 15..8, lower mask bits 7..0.
// - All four strobes low is mode set; address pins load the mode register.
// - RAS# high, CAS# low is column access; WE# picks read or write.
// - Mode selects sequential or interleaved order and length 1,2,4,8 or page.
// - Write data starts with the command, one word per edge, extra ignored.
// - New read cancels the old burst; old data runs until new latency.
// - CAS latency is two or three clocks to first read data.
module sdrci_core
    import sdrci_pkg::*;
#(
    parameter int P_STORE_ROW_BITS = ROW_W
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    input  wire logic              i_cke,
    input  wire logic              i_cs_n,
    input  wire logic              i_ras_n,
    input  wire logic              i_cas_n,
    input  wire logic              i_we_n,
    input  wire logic              i_bank_select_bit0,
    input  wire logic              i_bank_select_bit1,
    input  wire logic [ROW_W-1:0]  i_addr,
    input  wire logic              i_upper_byte_mask,
    input  wire logic              i_lower_byte_mask,
    input  wire logic [DQ_W-1:0]   i_dq,
    output logic      [DQ_W-1:0]   o_dq,
    output logic      [LANES-1:0]  o_dq_oe,
    output logic      [NBANK-1:0]  o_bank_open,
    output logic                   o_burst_busy,
    output sdrci_pwr_t             o_power_state
);
    localparam int ADDR_W = BANK_W + P_STORE_ROW_BITS + COL_W;

    // Storage array; shrink P_STORE_ROW_BITS for short simulations
    logic [DQ_W-1:0] mem [0:(2**ADDR_W)-1];

    logic [BANK_W-1:0]  bank_in;
    logic [2:0]         cmd;
    logic               cmd_live;
    logic               cmd_act;
    logic               cmd_pre;
    logic               cmd_rd;
    logic               cmd_wr;
    logic               cmd_mrs;
    logic               cmd_self;
    logic [LANES-1:0]   mask_in;

    logic [ROW_W-1:0]   mode_q;
    logic [MR_BL_W-1:0] bl_code;
    logic               cl3;
    logic [COL_W-1:0]   last_step;

    logic [NBANK-1:0]   open_q;
    logic [ROW_W-1:0]   row_q [NBANK];

    sdrci_bst_t         bst_q;
    logic [BANK_W-1:0]  bbank_q;
    logic [ROW_W-1:0]   brow_q;
    logic [COL_W-1:0]   start_q;
    logic [COL_W-1:0]   step_q;

    logic               wr_now;
    logic [ADDR_W-1:0]  wr_idx;
    logic [LANES-1:0]   wr_keep;

    logic               rd_cur;
    logic [DQ_W-1:0]    rd_data;
    logic               st1_valid_q;
    logic [DQ_W-1:0]    st1_data_q;
    logic [LANES-1:0]   mask_q;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    function automatic logic [ADDR_W-1:0] mem_index(input logic [BANK_W-1:0] bank,
                                                    input logic [ROW_W-1:0]  row,
                                                    input logic [COL_W-1:0]  col);
        return {bank, row[P_STORE_ROW_BITS-1:0], col};
    endfunction

    // Command decode
    assign bank_in  = {i_bank_select_bit1, i_bank_select_bit0};
    assign cmd      = {i_ras_n, i_cas_n, i_we_n};
    assign cmd_live = i_cke && !i_cs_n;
    assign cmd_act  = cmd_live && (cmd == CMD_ACTIVATE);
    assign cmd_pre  = cmd_live && (cmd == CMD_PRECHARGE);
    assign cmd_rd   = cmd_live && (cmd == CMD_READ);
    assign cmd_wr   = cmd_live && (cmd == CMD_WRITE);
    assign cmd_mrs  = cmd_live && (cmd == CMD_MODE_SET);
    assign cmd_self = !i_cke && !i_cs_n && (cmd == CMD_REFRESH);
    assign mask_in  = {i_upper_byte_mask, i_lower_byte_mask};

    a_cs_ignore: assert property ((i_cke && i_cs_n) |=>
        (mode_q == $past(mode_q)) && (open_q == $past(open_q)))
        else $error("deselected cycle changed device state");

    // Mode register
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_q <= MR_RESET;
        end else if (cmd_mrs) begin
            mode_q <= i_addr;
        end
    end

    assign bl_code   = mode_q[MR_BL_LSB +: MR_BL_W];
    assign cl3       = (mode_q[MR_CL_LSB +: MR_CL_W] == CL_THREE);
    assign last_step = sdrci_bl_mask(bl_code);

    a_mode_load: assert property (cmd_mrs |=> mode_q == $past(i_addr))
        else $error("mode set did not load the address pins");

    // Bank open state and latched rows
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            open_q <= '0;
            row_q  <= '{default: '0};
        end else if (cmd_act) begin
            open_q[bank_in] <= 1'b1;
            row_q[bank_in]  <= i_addr;
        end else if (cmd_pre) begin
            if (i_addr[PALL_BIT]) begin
                open_q <= '0;
            end else begin
                open_q[bank_in] <= 1'b0;
            end
        end
    end

    assign o_bank_open = open_q;

    a_act_open: assert property (cmd_act |=>
        open_q[$past(bank_in)] && (row_q[$past(bank_in)] == $past(i_addr)))
        else $error("activate did not open the selected bank");

    a_pre_all: assert property ((cmd_pre && i_addr[PALL_BIT]) |=> open_q == '0)
        else $error("precharge all left a bank open");

    a_pre_one: assert property ((cmd_pre && !i_addr[PALL_BIT]) |=>
        !open_q[$past(bank_in)] && ((open_q | $past(open_q)) == $past(open_q)))
        else $error("single precharge closed the wrong bank");

    // Burst engine, shared by reads and writes since one always cancels the other
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            bst_q   <= BST_IDLE;
            bbank_q <= '0;
            brow_q  <= '0;
            start_q <= '0;
            step_q  <= '0;
            o_burst_busy <= 1'b0;
        end else if (i_cke) begin
            if (cmd_rd || cmd_wr) begin
                bbank_q <= bank_in;
                brow_q  <= row_q[bank_in];
                start_q <= i_addr[COL_W-1:0];
                if (cmd_rd) begin
                    bst_q  <= BST_READ;
                    o_burst_busy <= 1'b1;
                    step_q <= '0;
                end else begin
                    // Word zero is stored with the command itself
                    step_q <= STEP_ONE;
                    bst_q  <= (last_step == BL_MASK_1) ? BST_IDLE : BST_WRITE;
                    o_burst_busy <= (last_step != BL_MASK_1);
                end
            end else begin
                case (bst_q)
                    BST_READ, BST_WRITE: begin
                        step_q <= step_q + STEP_ONE;
                        if (step_q == last_step) begin
                            bst_q <= BST_IDLE;
                            o_burst_busy <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Busy is kept as a flop beside the burst state so the pin has no decode behind it

    a_rd_restart: assert property (cmd_rd |=>
        (bst_q == BST_READ) && (step_q == '0) && (start_q == $past(i_addr[COL_W-1:0])))
        else $error("read did not restart the burst at its own column");

    a_burst_end: assert property ((i_cke && !cmd_rd && !cmd_wr && (bst_q != BST_IDLE)
        && (step_q == last_step)) |=> bst_q == BST_IDLE)
        else $error("burst ran past its programmed length");

    sdrci_burst_if u_bif ();
    assign u_bif.start_col  = start_q;
    assign u_bif.step       = step_q;
    assign u_bif.bl_code    = bl_code;
    assign u_bif.interleave = mode_q[MR_BT_BIT];

    sdrci_burst_gen u_gen (
        .bif (u_bif.gen)
    );

    // Write path; a read arriving mid burst drops the rest of the write
    always_comb begin
        wr_now = 1'b0;
        wr_idx = mem_index(bbank_q, brow_q, u_bif.col);
        if (cmd_wr) begin
            wr_now = 1'b1;
            wr_idx = mem_index(bank_in, row_q[bank_in], i_addr[COL_W-1:0]);
        end else if (i_cke && !cmd_rd && (bst_q == BST_WRITE)) begin
            wr_now = 1'b1;
        end
    end

    assign wr_keep = ~mask_in;

    always_ff @(posedge i_clk_sys) begin
        if (wr_now && wr_keep[0]) begin
            mem[wr_idx][BYTE_W-1:0] <= i_dq[BYTE_W-1:0];
        end
        if (wr_now && wr_keep[1]) begin
            mem[wr_idx][DQ_W-1:BYTE_W] <= i_dq[DQ_W-1:BYTE_W];
        end
    end

    a_wr_lo_lane: assert property ((wr_now && !i_lower_byte_mask) |=>
        ((mem[$past(wr_idx)] ^ $past(i_dq)) & LANE_LO) == '0)
        else $error("unmasked low byte was not written");

    a_wr_hi_keep: assert property ((wr_now && i_upper_byte_mask) |=>
        ((mem[$past(wr_idx)] ^ $past(mem[wr_idx])) & LANE_HI) == '0)
        else $error("masked high byte was overwritten");

    // Read path; the extra stage only serves latency three
    assign rd_cur  = (bst_q == BST_READ);
    assign rd_data = mem[mem_index(bbank_q, brow_q, u_bif.col)];

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_q      <= '0;
            st1_valid_q <= 1'b0;
            st1_data_q  <= '0;
        end else if (i_cke) begin
            mask_q      <= mask_in;
            st1_valid_q <= rd_cur && !cmd_wr;
            st1_data_q  <= rd_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_dq    <= '0;
            o_dq_oe <= '0;
        end else if (i_cke) begin
            if (cmd_wr) begin
                o_dq_oe <= '0;
            end else if (cl3) begin
                o_dq    <= st1_data_q;
                o_dq_oe <= {LANES{st1_valid_q}} & ~mask_q;
            end else begin
                o_dq    <= rd_data;
                o_dq_oe <= {LANES{rd_cur}} & ~mask_q;
            end
        end
    end

    a_rd_cl2: assert property ((cmd_rd && !cl3) ##1 (i_cke && !cmd_wr && !cmd_mrs
        && (mask_q == '0)) |=> o_dq_oe == '1)
        else $error("latency two read data not driven");

    a_rd_cl3: assert property ((cmd_rd && cl3) ##1 (i_cke && !cmd_wr && !cmd_mrs
        && (mask_in == '0)) ##1 (i_cke && !cmd_wr && !cmd_mrs) |=> o_dq_oe == '1)
        else $error("latency three read data not driven");

    a_mask_hiz: assert property ((i_cke && i_lower_byte_mask) ##1 i_cke |=>
        !o_dq_oe[0])
        else $error("masked read byte still driven two clocks later");

    a_wr_hiz: assert property ((cmd_wr || (bst_q == BST_WRITE)) && i_cke |=>
        o_dq_oe == '0)
        else $error("data outputs driven during a write");

    a_idle_hiz: assert property ((bst_q == BST_IDLE) && !st1_valid_q && i_cke |=>
        o_dq_oe == '0)
        else $error("data outputs driven with no read scheduled");

    a_freeze: assert property (!i_cke |=> $stable(open_q) && $stable(step_q)
        && $stable(o_dq_oe) && $stable(bst_q))
        else $error("state moved while clock enable was low");

    // Low-power indication follows clock enable every cycle so it can report the mode
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_power_state <= PWR_ACTIVE;
        end else if (i_cke) begin
            o_power_state <= PWR_ACTIVE;
        end else if (o_power_state == PWR_ACTIVE) begin
            if (cmd_self) begin
                o_power_state <= PWR_SELF;
            end else if (o_burst_busy) begin
                o_power_state <= PWR_SUSPEND;
            end else begin
                o_power_state <= PWR_DOWN;
            end
        end
    end

    a_pwr_entry: assert property ((!i_cke && (o_power_state == PWR_ACTIVE) && !cmd_self
        && o_burst_busy) |=> o_power_state == PWR_SUSPEND)
        else $error("clock enable low during a burst did not suspend");

endmodule // sdrci_core

/* hdl/sdrci_pkg.sv */
// Shared constants, types and helpers of the SDRAM command interface
package sdrci_pkg;

    localparam int ROW_W   = 12;
    localparam int COL_W   = 9;
    localparam int BANK_W  = 2;
    localparam int NBANK   = 4;
    localparam int DQ_W    = 16;
    localparam int BYTE_W  = 8;
    localparam int LANES   = 2;
    localparam int MR_BL_W = 3;
    localparam int MR_CL_W = 3;

    // Command codes as {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_MODE_SET  = 3'h0;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_READ      = 3'h5;

    // Mode register layout
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam logic [MR_CL_W-1:0] CL_THREE = 3'h3;
    localparam logic [ROW_W-1:0]   MR_RESET = 12'h020;

    // Burst length codes and the column bits each one lets wrap
    localparam logic [MR_BL_W-1:0] BL_CODE_2    = 3'h1;
    localparam logic [MR_BL_W-1:0] BL_CODE_4    = 3'h2;
    localparam logic [MR_BL_W-1:0] BL_CODE_8    = 3'h3;
    localparam logic [MR_BL_W-1:0] BL_CODE_FULL = 3'h7;
    localparam logic [COL_W-1:0]   BL_MASK_1    = 9'h000;
    localparam logic [COL_W-1:0]   BL_MASK_2    = 9'h001;
    localparam logic [COL_W-1:0]   BL_MASK_4    = 9'h003;
    localparam logic [COL_W-1:0]   BL_MASK_8    = 9'h007;
    localparam logic [COL_W-1:0]   BL_MASK_FULL = 9'h1FF;
    localparam logic [COL_W-1:0]   STEP_ONE     = 9'h001;

    // Address bit that widens a precharge to every bank
    localparam int PALL_BIT = 10;

    localparam logic [DQ_W-1:0] LANE_LO = 16'h00FF;
    localparam logic [DQ_W-1:0] LANE_HI = 16'hFF00;

    typedef enum logic [1:0] {BST_IDLE, BST_READ, BST_WRITE} sdrci_bst_t;
    typedef enum logic [1:0] {PWR_ACTIVE, PWR_SUSPEND, PWR_DOWN, PWR_SELF} sdrci_pwr_t;

    // Reserved length codes behave as a single word
    function automatic logic [COL_W-1:0] sdrci_bl_mask(input logic [MR_BL_W-1:0] code);
        case (code)
            BL_CODE_2:    return BL_MASK_2;
            BL_CODE_4:    return BL_MASK_4;
            BL_CODE_8:    return BL_MASK_8;
            BL_CODE_FULL: return BL_MASK_FULL;
            default:      return BL_MASK_1;
        endcase
    endfunction

endpackage
